/* core/cmd_fifo.sv */
// Command FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module cmd_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [PW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready = (cnt_reg != (PW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rp_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    mem_next = mem_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    if (push)
    begin
      mem_next[wp_reg] = in_data;
      wp_next = (wp_reg == PW'(DEPTH - 1)) ? '0 : wp_reg + PW'(1);
    end
    if (pop)
      rp_next = (rp_reg == PW'(DEPTH - 1)) ? '0 : rp_reg + PW'(1);
    cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= '0;
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      mem_reg <= mem_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule : cmd_fifo
`default_nettype wire

/* core/nand_strobe_timing_generator.sv */
// Top: AHB-Lite registers and NAND strobe sequencer for both controllers
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module nand_strobe_timing_generator
  import nand_timing_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output nand_out_t nand_pins,
  input wire logic [7:0] nand_din,
  input wire logic nand_rdy
);
  logic [31:0] mlc_reg, mlc_next, slc_reg, slc_next, ctrl_reg, ctrl_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic wr_pend_reg, wr_pend_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic accept, wr_commit, fifo_in_valid, fifo_in_ready;
  logic fifo_out_valid, pop, rdata_clear, capture;
  cmd_t fifo_out, cmd_reg, cmd_next;
  state_t state_reg, state_next;
  logic mode_reg, mode_next, lastw_reg, lastw_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  nand_out_t pins_reg, pins_next;
  logic [TMR_W-1:0] len;
  logic tmr_done, rd, rd_n, act;
  logic [3:0] wl, wh, rl, rh, rsu, rhd, rw, wsu, whd, ww;
  logic [2:0] ta;
  logic [4:0] bd;
  logic [1:0] cea;
  logic [TMR_W-1:0] phase_reg, phase_next, lo_reg, lo_next;

  function automatic logic [TMR_W-1:0] clamp1(logic [TMR_W-1:0] x);
    return (x == '0) ? TMR_ONE : x;
  endfunction : clamp1

  function automatic logic [TMR_W-1:0] diff(logic [3:0] h, logic [3:0] l);
    return (h > l) ? {2'h0, h - l} : '0;
  endfunction : diff

  // Timing fields
  assign wl = mlc_reg[MLC_WL_LSB +: FLD_W];
  assign wh = mlc_reg[MLC_WH_LSB +: FLD_W];
  assign rl = mlc_reg[MLC_RL_LSB +: FLD_W];
  assign rh = mlc_reg[MLC_RH_LSB +: FLD_W];
  assign ta = mlc_reg[MLC_TA_LSB +: MLC_TA_W];
  assign bd = mlc_reg[MLC_BD_LSB +: MLC_BD_W];
  assign cea = mlc_reg[MLC_CEA_LSB +: MLC_CEA_W];
  assign rsu = slc_reg[SLC_RSU_LSB +: FLD_W];
  assign rhd = slc_reg[SLC_RH_LSB +: FLD_W];
  assign rw = slc_reg[SLC_RW_LSB +: FLD_W];
  assign wsu = slc_reg[SLC_WSU_LSB +: FLD_W];
  assign whd = slc_reg[SLC_WH_LSB +: FLD_W];
  assign ww = slc_reg[SLC_WW_LSB +: FLD_W];

  // Bus slave: stall a command write while the FIFO is full
  assign accept = hsel && hready && htrans[1];
  assign fifo_in_valid = wr_pend_reg && (addr_reg == ADDR_CMD);
  assign hreadyout = !(fifo_in_valid && !fifo_in_ready);
  assign wr_commit = wr_pend_reg && hreadyout;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign rdata_clear = accept && !hwrite &&
    (haddr[ADDR_W-1:0] == ADDR_RDATA);

  always_comb
  begin
    mlc_next = mlc_reg;
    slc_next = slc_reg;
    ctrl_next = ctrl_reg;
    if (wr_commit && addr_reg == ADDR_MLC_TIMING)
      mlc_next = hwdata;
    if (wr_commit && addr_reg == ADDR_SLC_TIMING)
      slc_next = hwdata;
    if (wr_commit && addr_reg == ADDR_CTRL)
      ctrl_next = {31'h0, hwdata[CTRL_SLC_BIT]};
    wr_pend_next = accept ? hwrite : (wr_pend_reg && !hreadyout);
    addr_next = accept ? haddr[ADDR_W-1:0] : addr_reg;
    hrdata_next = hrdata_reg;
    if (accept && !hwrite)
    begin
      // Next values let a read see a write in its data phase
      case (haddr[ADDR_W-1:0])
        ADDR_MLC_TIMING: hrdata_next = mlc_next;
        ADDR_SLC_TIMING: hrdata_next = slc_next;
        ADDR_CTRL: hrdata_next = ctrl_next;
        ADDR_STATUS:
        begin
          hrdata_next = '0;
          hrdata_next[STAT_BUSY] = (state_reg != ST_IDLE);
          hrdata_next[STAT_EMPTY] = !fifo_out_valid;
          hrdata_next[STAT_FULL] = !fifo_in_ready;
          hrdata_next[STAT_RVALID] = rvalid_reg;
          hrdata_next[STAT_RDY] = nand_rdy;
        end
        ADDR_RDATA: hrdata_next = {24'h0, rdata_reg};
        default: hrdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mlc_reg <= MLC_TIMING_RST;
      slc_reg <= SLC_TIMING_RST;
      ctrl_reg <= CTRL_RST;
      wr_pend_reg <= 1'b0;
      addr_reg <= '0;
      hrdata_reg <= '0;
    end
    else
    begin
      mlc_reg <= mlc_next;
      slc_reg <= slc_next;
      ctrl_reg <= ctrl_next;
      wr_pend_reg <= wr_pend_next;
      addr_reg <= addr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  cmd_fifo #(
    .WIDTH(CMD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(hwdata[CMD_W-1:0]),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out)
  );

  // Sequencer; all delays in whole hclk periods
  assign rd = (cmd_reg.op == OP_READ);

  always_comb
  begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    mode_next = mode_reg;
    lastw_next = lastw_reg;
    pop = 1'b0;
    capture = 1'b0;
    unique case (state_reg)
      ST_IDLE:
        if (fifo_out_valid)
        begin
          pop = 1'b1;
          cmd_next = fifo_out;
          mode_next = ctrl_reg[CTRL_SLC_BIT];
          if (mode_next)
            state_next = ST_SETUP;
          else if (fifo_out.op == OP_READ)
            state_next = ST_CEA;
          else
            state_next = ST_LOW;
        end
      ST_CEA, ST_SETUP:
        if (tmr_done)
          state_next = ST_LOW;
      ST_LOW:
        if (tmr_done)
        begin
          state_next = ST_HIGH;
          capture = rd;
        end
      ST_HIGH:
        if (tmr_done)
        begin
          lastw_next = !rd;
          if (!mode_reg && rd)
            state_next = ST_TURN;
          else if (cmd_reg.wait_rdy)
            state_next = ST_BUSY;
          else
            state_next = ST_IDLE;
        end
      ST_TURN:
        if (tmr_done)
          state_next = cmd_reg.wait_rdy ? ST_BUSY : ST_IDLE;
      ST_BUSY:
        if (tmr_done)
          state_next = ST_READY;
      ST_READY:
        if (nand_rdy)
          state_next = ST_IDLE;
    endcase
  end

  // Length of the phase being entered
  always_comb
  begin
    rd_n = (cmd_next.op == OP_READ);
    len = TMR_ONE;
    unique case (state_next)
      ST_IDLE, ST_READY: len = TMR_ONE;
      ST_CEA: len = clamp1({4'h0, cea});
      ST_SETUP:
        if (!rd_n)
          len = clamp1({2'h0, wsu});
        else if (lastw_reg && wsu > rsu)
          len = clamp1({2'h0, wsu});
        else
          len = clamp1({2'h0, rsu});
      ST_LOW:
        if (mode_next)
          len = clamp1({2'h0, rd_n ? rw : ww});
        else if (rd_n)
          len = {2'h0, rl} + TMR_ONE;
        else
          len = {2'h0, wl} + TMR_ONE;
      ST_HIGH:
        if (mode_next)
          len = clamp1({2'h0, rd_n ? rhd : whd});
        else if (rd_n)
          len = clamp1(diff(rh, rl));
        else
          len = clamp1(diff(wh, wl));
      ST_TURN: len = clamp1({3'h0, ta});
      ST_BUSY:
        len = mode_next ? clamp1({2'h0, ww}) : clamp1({1'h0, bd});
    endcase
  end

  phase_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(state_next != state_reg),
    .value(len),
    .done(tmr_done)
  );

  // Pin values follow the state being entered
  always_comb
  begin
    act = (state_next == ST_SETUP) || (state_next == ST_LOW) ||
      (state_next == ST_HIGH);
    pins_next = pins_reg;
    pins_next.ce_n = (state_next == ST_IDLE);
    pins_next.re_n = !(state_next == ST_LOW && rd_n);
    pins_next.we_n = !(state_next == ST_LOW && !rd_n);
    pins_next.ale = act && (cmd_next.op == OP_ADDR);
    pins_next.cle = act && (cmd_next.op == OP_CMD);
    pins_next.doe_n = !(act && !rd_n);
    if (act && !rd_n)
      pins_next.dout = cmd_next.data;
    rdata_next = capture ? nand_din : rdata_reg;
    rvalid_next = capture || (rvalid_reg && !rdata_clear);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= ST_IDLE;
      cmd_reg <= '0;
      mode_reg <= 1'b0;
      lastw_reg <= 1'b0;
      pins_reg <= PINS_IDLE;
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      mode_reg <= mode_next;
      lastw_reg <= lastw_next;
      pins_reg <= pins_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign nand_pins = pins_reg;

  // Checking helpers: cycles in phase, cycles strobe low
  always_comb
  begin
    phase_next = (state_next == state_reg) ? phase_reg + TMR_ONE : '0;
    lo_next = (!pins_reg.re_n || !pins_reg.we_n) ? lo_reg + TMR_ONE : '0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_reg <= '0;
      lo_reg <= '0;
    end
    else
    begin
      phase_reg <= phase_next;
      lo_reg <= lo_next;
    end
  end

  AST_MLC_RE_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(nand_pins.re_n) && !mode_reg |-> lo_reg == {2'h0, rl} + TMR_ONE)
    else $error("read strobe low length wrong");
  AST_MLC_WE_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(nand_pins.we_n) && !mode_reg |-> lo_reg == {2'h0, wl} + TMR_ONE)
    else $error("write strobe low length wrong");
  AST_MLC_RE_HIGH: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_HIGH && state_next == ST_TURN |->
    phase_reg + TMR_ONE == clamp1(diff(rh, rl)))
    else $error("read strobe high length wrong");
  AST_MLC_WE_HIGH: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_HIGH && state_next != ST_HIGH && !mode_reg && !rd |->
    phase_reg + TMR_ONE == clamp1(diff(wh, wl)))
    else $error("write strobe high length wrong");
  AST_MLC_TURN: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_TURN && state_next != ST_TURN |->
    phase_reg + TMR_ONE == clamp1({3'h0, ta}) && nand_pins.doe_n)
    else $error("turnaround length wrong");
  AST_MLC_BUSY: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_BUSY && state_next != ST_BUSY && !mode_reg |->
    phase_reg + TMR_ONE == clamp1({1'h0, bd}))
    else $error("busy delay wrong");
  AST_MLC_CEA: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_CEA && state_next != ST_CEA |->
    phase_reg + TMR_ONE == clamp1({4'h0, cea}) && nand_pins.re_n)
    else $error("chip enable access delay wrong");
  AST_SLC_SETUP: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_SETUP && state_next == ST_LOW && rd |->
    phase_reg + TMR_ONE >= clamp1({2'h0, rsu}) &&
    (!lastw_reg || phase_reg + TMR_ONE >= clamp1({2'h0, wsu})))
    else $error("single-level setup too short");
  AST_SLC_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_SETUP && rd |-> nand_pins.doe_n && nand_pins.re_n)
    else $error("data driven during read setup");
  AST_SLC_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_HIGH && !rd |->
    !nand_pins.doe_n && nand_pins.dout == cmd_reg.data)
    else $error("write data not held");
  AST_SLC_BUSY: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_BUSY && state_next != ST_BUSY && mode_reg |->
    phase_reg + TMR_ONE == clamp1({2'h0, ww}))
    else $error("write width busy wait wrong");
  AST_IDLE_PINS: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_IDLE |-> nand_pins.ce_n && nand_pins.re_n &&
    nand_pins.we_n && !nand_pins.ale && !nand_pins.cle)
    else $error("pins not idle");
endmodule : nand_strobe_timing_generator
`default_nettype wire

/* core/nand_timing_pkg.sv */
// Package: register map, fields and types of the NAND strobe timer
// Overview of operation
// - Multi-level read strobe high lasts read-high minus read-low clocks
// - Multi-level write strobe low lasts write-low field plus one clocks
// - Multi-level write strobe high lasts write-high minus write-low clocks
// - Multi-level read: high phase plus turnaround before bus release
// - Multi-level first read strobe delayed chip-enable access clocks
// - Single-level strobe falls setup clocks after latch phase starts
// - Single-level data outputs released a read-setup before read strobe
// - Single-level read strobe falls at least read-setup clocks after chip enable falls
// - Single-level read after a write sets up the larger of write-setup and read-setup
// - Single-level read hold clocks let the flash release the bus
// - Single-level data held hold clocks, set up before strobe rise
// - Single-level write waits write-width clocks before ready check
// - Single-level read fields: setup, hold, width, ready wait (ready wait field unused; reads wait write-width clocks)
// - Single-level write fields: setup, hold, width, ready wait (ready wait field unused; write-width sets the wait)
package nand_timing_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_MLC_TIMING = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SLC_TIMING = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_RDATA = 8'h14;
  localparam logic [31:0] MLC_TIMING_RST = 32'h0000_0000;
  localparam logic [31:0] SLC_TIMING_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CTRL_SLC_BIT = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_EMPTY = 1;
  localparam int STAT_FULL = 2;
  localparam int STAT_RVALID = 3;
  localparam int STAT_RDY = 4;
  localparam int FLD_W = 4;
  localparam int MLC_WL_LSB = 0;
  localparam int MLC_WH_LSB = 4;
  localparam int MLC_RL_LSB = 8;
  localparam int MLC_RH_LSB = 12;
  localparam int MLC_TA_LSB = 16;
  localparam int MLC_TA_W = 3;
  localparam int MLC_BD_LSB = 19;
  localparam int MLC_BD_W = 5;
  localparam int MLC_CEA_LSB = 24;
  localparam int MLC_CEA_W = 2;
  localparam int SLC_RSU_LSB = 0;
  localparam int SLC_RH_LSB = 4;
  localparam int SLC_RW_LSB = 8;
  localparam int SLC_RRDY_LSB = 12;
  localparam int SLC_WSU_LSB = 16;
  localparam int SLC_WH_LSB = 20;
  localparam int SLC_WW_LSB = 24;
  localparam int SLC_WRDY_LSB = 28;
  localparam int TMR_W = 6;
  localparam logic [TMR_W-1:0] TMR_ONE = 6'h01;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [1:0] {OP_CMD, OP_ADDR, OP_WRITE, OP_READ} op_t;
  typedef struct packed {
    logic wait_rdy;
    op_t op;
    logic [7:0] data;
  } cmd_t;
  localparam int CMD_W = $bits(cmd_t);
  typedef struct packed {
    logic ce_n;
    logic re_n;
    logic we_n;
    logic ale;
    logic cle;
    logic doe_n;
    logic [7:0] dout;
  } nand_out_t;
  localparam nand_out_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0,
    1'b1, 8'h00};
  typedef enum logic [2:0] {ST_IDLE, ST_CEA, ST_SETUP, ST_LOW, ST_HIGH,
    ST_TURN, ST_BUSY, ST_READY} state_t;
endpackage : nand_timing_pkg

/* core/phase_timer.sv */
// Down-counter timing one strobe phase in bus clocks
`timescale 1ns/100ps
`default_nettype none
module phase_timer
  import nand_timing_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic load,
  input wire logic [TMR_W-1:0] value,
  output logic done
);
  logic [TMR_W-1:0] cnt_reg, cnt_next;

  // Phase ends in the cycle where one count remains
  assign done = (cnt_reg <= TMR_ONE);

  always_comb
  begin
    if (load)
      cnt_next = value;
    else if (cnt_reg != '0)
      cnt_next = cnt_reg - TMR_ONE;
    else
      cnt_next = cnt_reg;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end
endmodule : phase_timer
`default_nettype wire

/* verification/nand_flash_model.sv */
// Behavioural flash partner: data latch, read data and busy time
`timescale 1ns/100ps
`default_nettype none
module nand_flash_model
  import nand_timing_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire nand_out_t pins,
  input wire logic [7:0] busy_cycles,
  output logic [7:0] din,
  output logic rdy
);
  logic [7:0] byte_reg;
  logic [7:0] last_reg;
  logic [7:0] busy_reg;
  logic re_d_reg;
  logic we_d_reg;
  logic drive_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      byte_reg <= 8'h00;
      last_reg <= 8'h00;
      busy_reg <= 8'h00;
      re_d_reg <= 1'b1;
      we_d_reg <= 1'b1;
      drive_reg <= 1'b0;
    end
    else
    begin
      re_d_reg <= pins.re_n;
      we_d_reg <= pins.we_n;
      // Only data bytes are stored, not commands or addresses
      if (!pins.we_n && !pins.doe_n && !pins.ale && !pins.cle)
        byte_reg <= pins.dout;
      if ((pins.re_n && !re_d_reg) || (pins.we_n && !we_d_reg))
        busy_reg <= busy_cycles;
      else if (busy_reg != 8'h00)
        busy_reg <= busy_reg - 8'h01;
      drive_reg <= !pins.re_n;
      if (drive_reg || !pins.re_n)
        last_reg <= din;
    end
  end
  // Released bus shows the inverse of the last byte
  assign din = (drive_reg || !pins.re_n) ? byte_reg ^ 8'h3c : ~last_reg;
  assign rdy = (busy_reg == 8'h00);
endmodule : nand_flash_model
`default_nettype wire

/* verification/test_nand_strobe_timing_generator.sv */
// Testbench: bus tasks, pin monitor and scoreboard for the strobe timer
`timescale 1ns/100ps
`default_nettype none
module test_nand_strobe_timing_generator
  import nand_timing_pkg::*;
;
  typedef struct {
    int lead;
    int low;
    int tail;
    bit tmin;
    bit rd;
    logic [7:0] d;
    logic [2:0] lat;
  } pulse_exp_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, nand_rdy;
  logic [31:0] haddr, hwdata, hrdata, mlc_v, slc_v, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] nand_din, busy_cycles, last_wd;
  logic [63:0] bq;
  nand_out_t nand_pins;
  logic [63:0] bus_q[$];
  pulse_exp_t pin_q[$];
  pulse_exp_t pe;
  int num_errors, cmp_count, k, o, lead, low, tail;
  bit slc, rd_pend, prev_we;

  nand_strobe_timing_generator i_nand_strobe_timing_generator (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .nand_pins(nand_pins), .nand_din(nand_din),
    .nand_rdy(nand_rdy));
  nand_flash_model i_nand_flash_model (.hclk(hclk), .hresetn(hresetn),
    .pins(nand_pins), .busy_cycles(busy_cycles), .din(nand_din),
    .rdy(nand_rdy));

  function automatic int mx(input int a, input int b);
    return a > b ? a : b;
  endfunction : mx

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp,
    input logic [31:0] m);
    cmp_count++;
    if ((got & m) !== (exp & m))
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic wait_ready();
    int n;
    n = 0;
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1 && ++n < 2000);
    if (n >= 2000)
      cmp_val(32'h0, 32'h1, '1);
  endtask : wait_ready

  task automatic ahb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, input logic [31:0] ev, input logic [31:0] em);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    if (!wr)
      bus_q.push_back({ev, em});
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : ahb

  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    ahb(1'b1, a, v, 32'h0, 32'h0);
  endtask : wreg

  task automatic rreg(input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m);
    ahb(1'b0, a, 32'h0, e, m);
  endtask : rreg

  task automatic idle();
    int n;
    n = 0;
    do
      rreg(ADDR_STATUS, 32'h0, 32'h0);
    while ((rd[1] !== 1'b1 || rd[0] !== 1'b0) && ++n < 1000);
    if (n >= 1000)
      cmp_val(32'h0, 32'h1, '1);
  endtask : idle

  task automatic send(input op_t op, input logic [7:0] d, input logic w);
    pulse_exp_t e;
    int wt;
    bit r;
    r = (op == OP_READ);
    e.rd = r;
    e.d = d;
    e.lat = {op == OP_ADDR, op == OP_CMD, r};
    e.tmin = w;
    if (!slc)
    begin
      e.low = int'(r ? mlc_v[11:8] : mlc_v[3:0]) + 1;
      e.lead = r ? mx(int'(mlc_v[25:24]), 1) : 0;
      e.tail = r ? mx(int'(mlc_v[15:12]) - int'(mlc_v[11:8]), 1)
        + mx(int'(mlc_v[18:16]), 1)
        : mx(int'(mlc_v[7:4]) - int'(mlc_v[3:0]), 1);
      wt = mx(int'(mlc_v[23:19]), 1);
    end
    else
    begin
      e.low = mx(int'(r ? slc_v[11:8] : slc_v[27:24]), 1);
      e.lead = !r ? mx(int'(slc_v[19:16]), 1) : prev_we ?
        mx(mx(int'(slc_v[19:16]), int'(slc_v[3:0])), 1)
        : mx(int'(slc_v[3:0]), 1);
      e.tail = mx(int'(r ? slc_v[7:4] : slc_v[23:20]), 1);
      wt = mx(int'(slc_v[27:24]), 1);
    end
    if (w)
      e.tail = mx(e.tail + wt, int'(busy_cycles));
    prev_we = !r;
    if (op == OP_WRITE)
      last_wd = d;
    pin_q.push_back(e);
    wreg(ADDR_CMD, {21'h000000, w, op, d});
  endtask : send

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  always @(posedge hclk)
  begin
    if (hresetn === 1'b1)
    begin
      if (rd_pend && hreadyout)
      begin
        bq = bus_q.pop_front();
        if (bq[31:0] != 32'h0)
          cmp_val(hrdata, bq[63:32], bq[31:0]);
        cmp_val(32'(hresp), 32'h0, '1);
        rd_pend = 1'b0;
      end
      if (hsel && hreadyout && htrans[1] && !hwrite)
        rd_pend = 1'b1;
      if (!nand_pins.ce_n)
      begin
        if (!nand_pins.re_n || !nand_pins.we_n)
        begin
          if (low == 0)
          begin
            pe = pin_q.pop_front();
            cmp_val(lead, pe.lead, '1);
            cmp_val(32'({nand_pins.ale, nand_pins.cle, nand_pins.doe_n,
              !nand_pins.re_n}), 32'({pe.lat, pe.rd}), '1);
            if (!pe.rd)
              cmp_val(32'(nand_pins.dout), 32'(pe.d), '1);
          end
          low++;
        end
        else if (low == 0)
          lead++;
        else
          tail++;
      end
      else
      begin
        if (low != 0)
        begin
          cmp_val(low, pe.low, '1);
          if (pe.tmin)
            cmp_val(32'(tail >= pe.tail), 32'h1, '1);
          else
            cmp_val(tail, pe.tail, '1);
        end
        lead = 0;
        low = 0;
        tail = 0;
        cmp_val(32'({nand_pins.re_n, nand_pins.we_n, nand_pins.ale,
          nand_pins.cle}), 32'h0000_000c, '1);
      end
    end
  end

  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial
  begin
    #80000;
    num_errors++;
    end_of_test();
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    busy_cycles = 8'h00;
    rd = $urandom(32'h2b4739fa);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rreg(ADDR_MLC_TIMING, MLC_TIMING_RST, '1);
    rreg(ADDR_SLC_TIMING, SLC_TIMING_RST, '1);
    rreg(ADDR_CTRL, CTRL_RST, '1);
    rreg(ADDR_STATUS, 32'h2, 32'hf);
    rreg(ADDR_CMD, 32'h0, '1);
    wreg(8'h40, '1);
    rreg(8'h40, 32'h0, '1);
    // Zero timings first, then random timings in both modes
    for (k = 0; k < 14; k++)
    begin
      slc = k[0];
      mlc_v = k < 2 ? 32'h0 : $urandom;
      slc_v = k < 2 ? 32'h0 : $urandom;
      wreg(ADDR_MLC_TIMING, mlc_v);
      wreg(ADDR_SLC_TIMING, slc_v);
      wreg(ADDR_CTRL, {31'h0, slc});
      rreg(ADDR_MLC_TIMING, mlc_v, 32'h03ff_ffff);
      rreg(ADDR_SLC_TIMING, slc_v, '1);
      for (o = 0; o < 4; o++)
        send(op_t'(o), 8'($urandom), 1'b0);
      idle();
      rreg(ADDR_STATUS, 32'h8, 32'h8);
      rreg(ADDR_RDATA, {24'h0, last_wd ^ 8'h3c}, '1);
      rreg(ADDR_STATUS, 32'h0, 32'h8);
    end
    // Ready wait with a prompt and a slow flash
    for (k = 0; k < 2; k++)
    begin
      slc = k[0];
      busy_cycles <= k[0] ? 8'h1e : 8'h00;
      wreg(ADDR_CTRL, {31'h0, slc});
      send(OP_WRITE, 8'h5a, 1'b1);
      send(OP_READ, 8'h00, 1'b1);
      idle();
      rreg(ADDR_RDATA, {24'h0, 8'h5a ^ 8'h3c}, '1);
    end
    // Slow flash lets the command queue fill and stall the bus
    busy_cycles <= 8'h28;
    @(posedge hclk);
    for (k = 0; k < 11; k++)
    begin
      send(OP_WRITE, 8'(k), 1'b1);
      if (k == 8)
        rreg(ADDR_STATUS, 32'h4, 32'h4);
    end
    idle();
    rreg(ADDR_STATUS, 32'h12, 32'h1f);
    @(posedge hclk);
    end_of_test();
  end
endmodule : test_nand_strobe_timing_generator
`default_nettype wire
